// [cwg_pkg.sv]
// package: register map, field positions and constants of the complementary waveform generator
package cwg_pkg;
    // register byte addresses
    localparam logic [7:0] CWG_CTRL_ADDR     = 8'h00;
    localparam logic [7:0] CWG_SRC_ADDR      = 8'h04;
    localparam logic [7:0] CWG_SHUT_ADDR     = 8'h08;
    localparam logic [7:0] CWG_DB_RISE_ADDR  = 8'h0c;
    localparam logic [7:0] CWG_DB_FALL_ADDR  = 8'h10;
    localparam logic [7:0] CWG_STATUS_ADDR   = 8'h14;
    // control register fields
    localparam int CTRL_MODULE_ENABLE  = 7;
    localparam int CTRL_PIN_ENABLE_B   = 6;
    localparam int CTRL_PIN_ENABLE_A   = 5;
    localparam int CTRL_POLARITY_B     = 4;
    localparam int CTRL_POLARITY_A     = 3;
    localparam int CTRL_CLOCK_SELECT   = 0;
    // source register fields
    localparam int SRC_LEVEL_B         = 7;
    localparam int SRC_LEVEL_A         = 6;
    localparam int SRC_SELECT_LSB      = 0;
    // shutdown register fields
    localparam int SHUT_SOFT_ACTIVE    = 7;
    localparam int SHUT_AUTO_RESTART   = 6;
    localparam int SHUT_SRC_FAULT_PIN  = 3;
    localparam int SHUT_SRC_LOGIC2     = 2;
    localparam int SHUT_SRC_CMP2       = 1;
    localparam int SHUT_SRC_CMP1       = 0;
    // status register fields
    localparam int STAT_IN_SHUTDOWN    = 4;
    localparam int STAT_INPUT_LEVEL    = 3;
    localparam int STAT_OUT_B          = 1;
    localparam int STAT_OUT_A          = 0;
    // reset values
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] SRC_RESET   = 8'h00;
    localparam logic [7:0] SHUT_RESET  = 8'h00;
    localparam logic [5:0] DB_RESET    = 6'h00;
    // dead-band counter width
    localparam int DB_WIDTH            = 6;
    // internal oscillator rate and its phase-accumulator step per system clock
    localparam int SYS_CLOCK_HZ        = 50_000_000;
    localparam int FAST_OSC_HZ         = 16_000_000;
    localparam int PHASE_WIDTH         = 8;
    localparam logic [PHASE_WIDTH-1:0] FAST_OSC_STEP =
        PHASE_WIDTH'((longint'(FAST_OSC_HZ) << PHASE_WIDTH) / longint'(SYS_CLOCK_HZ));
    // answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {CWG_IDLE, CWG_RISE_WAIT, CWG_FALL_WAIT} cwg_phase_t;
endpackage

// [cwg_deadband.sv]
// dead-band edge timer: counts tick periods after an edge, then signals expiry
`timescale 1ns/10ps
module cwg_deadband #(
    parameter int WIDTH = 6
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic             tick,
    input  wire logic [WIDTH-1:0] count,
    output logic                  busy,
    output logic                  done
);
    logic [WIDTH-1:0] cnt_r;

    // zero count gives done in the start cycle itself
    always_comb begin
        done = (start && count == '0) || (busy && !start && tick && cnt_r + WIDTH'(1) >= count);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || abort) begin
            busy  <= 1'b0;
            cnt_r <= '0;
        end else if (start) begin
            busy  <= (count != '0);
            cnt_r <= '0;
        end else if (done) begin
            busy  <= 1'b0;
        end else if (busy && tick) begin
            cnt_r <= cnt_r + WIDTH'(1);
        end
    end
endmodule

// [cwg_top.sv]
// complementary waveform generator with dead band, auto-shutdown and an AXI4-Lite register slave
// Functional notes
// - two outputs from one selected input
// - dead interval between the two outputs
// - two independent six-bit edge counters
// - dead-band clock: system or 16 MHz
// - three-bit field picks one of eight
// - both drives cleared right after enable
// - cleared pin enable releases that pin
// - enabled pin gets override or waveform
// - module disabled: pins entirely released
// - polarity bit set means active high
// - override levels never inverted by polarity
// - auto-shutdown with sources, restart, levels
// - rising edge: B off, A later
// - falling edge: A off, B later
// - count zero means no dead band
// - shutdown drives the configured override levels
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module cwg_top #(
    parameter int DB_BITS = cwg_pkg::DB_WIDTH
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        comparator1_synced_out,
    input  wire logic        comparator2_synced_out,
    input  wire logic        pwm_channel1_out,
    input  wire logic        pwm_channel2_out,
    input  wire logic        pwm_channel3_out,
    input  wire logic        pwm_channel4_out,
    input  wire logic        numeric_oscillator_out,
    input  wire logic        logic_cell1_out,
    input  wire logic        comparator1_async_out,
    input  wire logic        comparator2_async_out,
    input  wire logic        logic_cell2_out,
    input  wire logic        fault_pin,
    output logic             drive_output_a,
    output logic             drive_output_a_oe,
    output logic             drive_output_b,
    output logic             drive_output_b_oe
);
    logic [7:0]         ctrl_r;
    logic [7:0]         src_r;
    logic [7:0]         shut_r;
    logic [DB_BITS-1:0] db_rise_r;
    logic [DB_BITS-1:0] db_fall_r;
    logic               aw_got_r;
    logic               w_got_r;
    logic [7:0]         awaddr_r;
    logic [31:0]        wdata_r;
    logic [3:0]         wstrb_r;
    logic [7:0]         in_s1_r;
    logic [7:0]         in_s2_r;
    logic [3:0]         flt_s1_r;
    logic [3:0]         flt_s2_r;
    logic               sel_prev_r;
    logic [cwg_pkg::PHASE_WIDTH-1:0] phase_r;
    logic               tick_r;
    logic               en_prev_r;
    logic               wave_a_r;
    logic               wave_b_r;
    logic               shutdown_r;
    logic               soft_active_r;
    logic               out_a_r;
    logic               out_b_r;
    logic               oe_a_r;
    logic               oe_b_r;

    logic        module_enable;
    logic        output_a_pin_enable;
    logic        output_b_pin_enable;
    logic        output_a_polarity;
    logic        output_b_polarity;
    logic        deadband_clock_select;
    logic [2:0]  input_source_select;
    logic        shutdown_level_a;
    logic        shutdown_level_b;
    logic        sel_in;
    logic        rise_edge;
    logic        fall_edge;
    logic        db_tick;
    logic        rise_busy;
    logic        rise_done;
    logic        fall_busy;
    logic        fall_done;
    logic        fault_hit;
    logic        do_write;
    logic        restart_ok;

    assign module_enable         = ctrl_r[cwg_pkg::CTRL_MODULE_ENABLE];
    assign output_a_pin_enable   = ctrl_r[cwg_pkg::CTRL_PIN_ENABLE_A];
    assign output_b_pin_enable   = ctrl_r[cwg_pkg::CTRL_PIN_ENABLE_B];
    assign output_a_polarity     = ctrl_r[cwg_pkg::CTRL_POLARITY_A];
    assign output_b_polarity     = ctrl_r[cwg_pkg::CTRL_POLARITY_B];
    assign deadband_clock_select = ctrl_r[cwg_pkg::CTRL_CLOCK_SELECT];
    assign input_source_select   = src_r[cwg_pkg::SRC_SELECT_LSB +: 3];
    assign shutdown_level_a      = src_r[cwg_pkg::SRC_LEVEL_A];
    assign shutdown_level_b      = src_r[cwg_pkg::SRC_LEVEL_B];

    // ---------------- AXI4-Lite write channel ----------------
    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
    assign do_write      = aw_got_r && w_got_r && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cwg_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            case (awaddr_r)
                cwg_pkg::CWG_CTRL_ADDR, cwg_pkg::CWG_SRC_ADDR, cwg_pkg::CWG_SHUT_ADDR,
                cwg_pkg::CWG_DB_RISE_ADDR, cwg_pkg::CWG_DB_FALL_ADDR, cwg_pkg::CWG_STATUS_ADDR:
                    s_axi_bresp <= cwg_pkg::RESP_OKAY;
                default:
                    s_axi_bresp <= cwg_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // configuration registers, byte lane 0 only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r    <= cwg_pkg::CTRL_RESET;
            src_r     <= cwg_pkg::SRC_RESET;
            db_rise_r <= DB_BITS'(cwg_pkg::DB_RESET);
            db_fall_r <= DB_BITS'(cwg_pkg::DB_RESET);
        end else if (do_write && wstrb_r[0]) begin
            case (awaddr_r)
                cwg_pkg::CWG_CTRL_ADDR:    ctrl_r    <= wdata_r[7:0] & 8'hf9;
                cwg_pkg::CWG_SRC_ADDR:     src_r     <= wdata_r[7:0] & 8'hc7;
                cwg_pkg::CWG_DB_RISE_ADDR: db_rise_r <= wdata_r[DB_BITS-1:0];
                cwg_pkg::CWG_DB_FALL_ADDR: db_fall_r <= wdata_r[DB_BITS-1:0];
                default: ;
            endcase
        end
    end

    // ---------------- AXI4-Lite read channel ----------------
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= cwg_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= cwg_pkg::RESP_OKAY;
            case (s_axi_araddr)
                cwg_pkg::CWG_CTRL_ADDR:    s_axi_rdata <= {24'h000000, ctrl_r};
                cwg_pkg::CWG_SRC_ADDR:     s_axi_rdata <= {24'h000000, src_r};
                cwg_pkg::CWG_SHUT_ADDR:    s_axi_rdata <= {24'h000000, soft_active_r, shut_r[6:0]};
                cwg_pkg::CWG_DB_RISE_ADDR: s_axi_rdata <= 32'(db_rise_r);
                cwg_pkg::CWG_DB_FALL_ADDR: s_axi_rdata <= 32'(db_fall_r);
                cwg_pkg::CWG_STATUS_ADDR:  s_axi_rdata <= {27'h0000000, shutdown_r, sel_prev_r, 1'b0, out_b_r, out_a_r};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= cwg_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- input synchronisers and source select ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_s1_r  <= 8'h00;
            in_s2_r  <= 8'h00;
            flt_s1_r <= 4'h0;
            flt_s2_r <= 4'h0;
        end else begin
            in_s1_r  <= {logic_cell1_out, numeric_oscillator_out, pwm_channel4_out, pwm_channel3_out,
                         pwm_channel2_out, pwm_channel1_out, comparator2_synced_out, comparator1_synced_out};
            in_s2_r  <= in_s1_r;
            flt_s1_r <= {fault_pin, logic_cell2_out, comparator2_async_out, comparator1_async_out};
            flt_s2_r <= flt_s1_r;
        end
    end

    assign sel_in    = in_s2_r[input_source_select];
    assign rise_edge = module_enable && sel_in && !sel_prev_r;
    assign fall_edge = module_enable && !sel_in && sel_prev_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_prev_r <= 1'b0;
        end else begin
            sel_prev_r <= sel_in;
        end
    end

    // ---------------- dead-band clock ----------------
    // fast oscillator modelled as a phase accumulator ticking at about 15.8 MHz average (step 81 of 256 per 50 MHz clock)
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= '0;
            tick_r  <= 1'b0;
        end else begin
            {tick_r, phase_r} <= {1'b0, phase_r} + {1'b0, cwg_pkg::FAST_OSC_STEP};
        end
    end

    assign db_tick = deadband_clock_select ? tick_r : 1'b1;

    cwg_deadband #(.WIDTH(DB_BITS)) u_rise (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (rise_edge),
        .abort   (fall_edge || !module_enable),
        .tick    (db_tick),
        .count   (db_rise_r),
        .busy    (rise_busy),
        .done    (rise_done)
    );

    cwg_deadband #(.WIDTH(DB_BITS)) u_fall (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (fall_edge),
        .abort   (rise_edge || !module_enable),
        .tick    (db_tick),
        .count   (db_fall_r),
        .busy    (fall_busy),
        .done    (fall_done)
    );

    // ---------------- active waveform ----------------
    always_ff @(posedge aclk) begin
        en_prev_r <= aresetn && module_enable;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !module_enable || !en_prev_r) begin
            wave_a_r <= 1'b0;
            wave_b_r <= 1'b0;
        end else begin
            if (rise_edge) begin
                wave_b_r <= 1'b0;
            end else if (fall_done) begin
                wave_b_r <= 1'b1;
            end
            if (fall_edge) begin
                wave_a_r <= 1'b0;
            end else if (rise_done) begin
                wave_a_r <= 1'b1;
            end
        end
    end

    // ---------------- auto-shutdown ----------------
    assign fault_hit = |(flt_s2_r & shut_r[3:0]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shut_r <= cwg_pkg::SHUT_RESET;
        end else if (do_write && wstrb_r[0] && awaddr_r == cwg_pkg::CWG_SHUT_ADDR) begin
            shut_r <= wdata_r[7:0] & 8'h4f;
        end
    end

    // fault sets the flag and wins over a software clear; auto-restart clears it when faults drop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_active_r <= 1'b0;
        end else if (fault_hit) begin
            soft_active_r <= 1'b1;
        end else if (do_write && wstrb_r[0] && awaddr_r == cwg_pkg::CWG_SHUT_ADDR) begin
            soft_active_r <= wdata_r[cwg_pkg::SHUT_SOFT_ACTIVE];
        end else if (shut_r[cwg_pkg::SHUT_AUTO_RESTART]) begin
            soft_active_r <= 1'b0;
        end
    end

    // overrides persist until the first rising edge after the flag clears
    assign restart_ok = !soft_active_r && !fault_hit && rise_edge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shutdown_r <= 1'b0;
        end else if (soft_active_r || fault_hit) begin
            shutdown_r <= 1'b1;
        end else if (restart_ok) begin
            shutdown_r <= 1'b0;
        end
    end

    // ---------------- pin drive ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_a_r <= 1'b0;
            out_b_r <= 1'b0;
            oe_a_r  <= 1'b0;
            oe_b_r  <= 1'b0;
        end else begin
            oe_a_r <= module_enable && output_a_pin_enable;
            oe_b_r <= module_enable && output_b_pin_enable;
            if (shutdown_r || soft_active_r || fault_hit) begin
                out_a_r <= shutdown_level_a;
                out_b_r <= shutdown_level_b;
            end else begin
                out_a_r <= output_a_polarity ? wave_a_r : !wave_a_r;
                out_b_r <= output_b_polarity ? wave_b_r : !wave_b_r;
            end
        end
    end

    assign drive_output_a    = out_a_r;
    assign drive_output_b    = out_b_r;
    assign drive_output_a_oe = oe_a_r;
    assign drive_output_b_oe = oe_b_r;

    // unused bus qualifiers and status of counters
    logic unused_ok;
    assign unused_ok = &{1'b0, s_axi_awprot, s_axi_arprot, rise_busy, fall_busy, wstrb_r[3:1], wdata_r[31:8]};
endmodule

// [cwg_gate_model.sv]
// gate driver model: resolves the two released-or-driven output pins
`timescale 1ns/10ps
module cwg_gate_model (
    input  wire logic pin_a,
    input  wire logic oe_a,
    input  wire logic pin_b,
    input  wire logic oe_b,
    output logic      gate_a,
    output logic      gate_b
);
    // a released pin is pulled down at the driver input
    assign gate_a = oe_a ? pin_a : 1'b0;
    assign gate_b = oe_b ? pin_b : 1'b0;
endmodule

// [cwg_checker.sv]
// checker: bus handshake and pin-enable relations of the waveform generator
`timescale 1ns/10ps
module cwg_checker #(
    parameter int DB_BITS = 6
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        drive_output_a_oe,
    input wire logic        drive_output_b_oe
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken_s;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // an enable change can only follow a completed register write
    sequence cfg_done_s;
        s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
    endsequence
    write_answer_a: assert property (wr_taken_s |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    read_answer_a: assert property (rd_taken_s |=> s_axi_rvalid) else $error("read not answered");
    bvalid_drop_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready)) else $error("bvalid dropped early");
    rvalid_drop_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready)) else $error("rvalid dropped early");
    read_gate_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready while rvalid");
    write_gate_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("awready while bvalid");
    read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
    error_data_a: assert property (s_axi_rvalid && s_axi_rresp == cwg_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read with data");
    oe_a_cause_a: assert property ($changed(drive_output_a_oe) |-> cfg_done_s) else $error("oe a moved alone");
    oe_b_cause_a: assert property ($changed(drive_output_b_oe) |-> cfg_done_s) else $error("oe b moved alone");
endmodule
bind cwg_top cwg_checker #(.DB_BITS(DB_BITS)) u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .drive_output_a_oe, .drive_output_b_oe);

// [tb_cwg_top.sv]
// testbench: registers, dead band, polarity, shutdown and pin enables of the waveform generator
`timescale 1ns/10ps
module tb_cwg_top;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pa, pa_oe, pb, pb_oe, gate_a, gate_b;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, srcv;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb, flt;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          err_count, comparisons, s, g;
    cwg_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .comparator1_synced_out(srcv[0]), .comparator2_synced_out(srcv[1]), .pwm_channel1_out(srcv[2]),
        .pwm_channel2_out(srcv[3]), .pwm_channel3_out(srcv[4]), .pwm_channel4_out(srcv[5]),
        .numeric_oscillator_out(srcv[6]), .logic_cell1_out(srcv[7]), .comparator1_async_out(flt[0]),
        .comparator2_async_out(flt[1]), .logic_cell2_out(flt[2]), .fault_pin(flt[3]), .drive_output_a(pa),
        .drive_output_a_oe(pa_oe), .drive_output_b(pb), .drive_output_b_oe(pb_oe));
    cwg_gate_model u_gate (.pin_a(pa), .oe_a(pa_oe), .pin_b(pb), .oe_b(pb_oe), .gate_a, .gate_b);
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang;
        err_count++;
        $display("wrong value at %0t: wait ran out", $time);
        tally_and_finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 100) hang;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 100) hang;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        rd(a);
        chk(d, exp);
        chk(32'(r), 32'(er));
    endtask
    task automatic pulse(input logic v);
        @(posedge aclk);
        srcv <= v ? 8'(1 << s) : 8'h0;
    endtask
    function automatic logic pin(input int sel);
        return sel ? gate_b : gate_a;
    endfunction
    // cycles from one pin turning off to the other turning on
    task automatic gap(input int off, input int lo, input int hi);
        int n;
        for (n = 0; n < 300; n++) begin
            @(negedge aclk);
            if (pin(off) === 1'b0) break;
        end
        for (g = 0; g < 300 && pin(1 - off) !== 1'b1; g++) @(negedge aclk);
        if (n == 300 || g == 300) hang;
        chk({31'h0, g >= lo && g <= hi}, 32'h1);
    endtask
    task automatic pins(input logic [1:0] exp);
        repeat (6) @(negedge aclk);
        chk({30'h0, gate_a, gate_b}, {30'h0, exp});
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, srcv, s_axi_wdata, s_axi_wstrb, flt} = '0;
        err_count = 0;
        comparisons = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // pins idle high while both polarities reset to active low
        for (s = 0; s < 6; s++) rc(8'(s * 4), (s == 5) ? 32'h3 : 32'h0, cwg_pkg::RESP_OKAY);
        rc(8'h18, 32'h0, cwg_pkg::RESP_SLVERR);
        chk({30'h0, pa_oe, pb_oe}, 32'h0);
        wr(8'h18, 32'hff, 4'hf);
        chk(32'(r), 32'(cwg_pkg::RESP_SLVERR));
        wr(cwg_pkg::CWG_DB_FALL_ADDR, 32'h5, 4'h0);
        rc(cwg_pkg::CWG_DB_FALL_ADDR, 32'h0, cwg_pkg::RESP_OKAY);
        wr(cwg_pkg::CWG_DB_RISE_ADDR, 32'h3, 4'h1);
        wr(cwg_pkg::CWG_CTRL_ADDR, 32'hf8, 4'h1);
        for (g = 0; g < 50 && pa_oe !== 1'b1; g++) @(negedge aclk);
        chk({30'h0, gate_a, gate_b}, 32'h0);
        chk({30'h0, pa_oe, pb_oe}, 32'h3);
        for (s = 0; s < 8; s++) begin
            wr(cwg_pkg::CWG_SRC_ADDR, 32'(s), 4'h1);
            pulse(1'b1);
            gap(1, 0, 300);
            pulse(1'b0);
            gap(0, 0, 0);
            pulse(1'b1);
            gap(1, 3, 3);
            pulse(1'b0);
            gap(0, 0, 0);
        end
        s = 7;
        wr(cwg_pkg::CWG_DB_RISE_ADDR, 32'hff, 4'h1);
        rc(cwg_pkg::CWG_DB_RISE_ADDR, 32'h3f, cwg_pkg::RESP_OKAY);
        pulse(1'b1);
        gap(1, 63, 63);
        wr(cwg_pkg::CWG_DB_RISE_ADDR, 32'h8, 4'h1);
        wr(cwg_pkg::CWG_CTRL_ADDR, 32'hf9, 4'h1);
        pulse(1'b0);
        gap(0, 0, 0);
        pulse(1'b1);
        gap(1, 21, 29);
        pulse(1'b0);
        gap(0, 0, 0);
        for (s = 0; s < 4; s++) begin
            wr(cwg_pkg::CWG_CTRL_ADDR, 32'he0 | 32'(s << 3), 4'h1);
            pins({~s[0], s[1]});
        end
        s = 7;
        wr(cwg_pkg::CWG_CTRL_ADDR, 32'hf8, 4'h1);
        wr(cwg_pkg::CWG_SRC_ADDR, 32'h47, 4'h1);
        wr(cwg_pkg::CWG_SHUT_ADDR, 32'h80, 4'h1);
        pins(2'b10);
        wr(cwg_pkg::CWG_SHUT_ADDR, 32'h0, 4'h1);
        pins(2'b10);
        pulse(1'b1);
        pulse(1'b0);
        // override ends at the rising edge, b comes back one cycle later at the fall
        gap(0, 1, 1);
        wr(cwg_pkg::CWG_CTRL_ADDR, 32'he0, 4'h1);
        wr(cwg_pkg::CWG_SRC_ADDR, 32'h87, 4'h1);
        for (g = 0; g < 4; g++) begin
            wr(cwg_pkg::CWG_SHUT_ADDR, 32'h40 | 32'(1 << g), 4'h1);
            flt <= 4'(1 << g);
            pins(2'b01);
            rd(cwg_pkg::CWG_STATUS_ADDR);
            chk({31'h0, d[4]}, 32'h1);
            flt <= 4'h0;
            repeat (8) @(negedge aclk);
            rd(cwg_pkg::CWG_SHUT_ADDR);
            chk({31'h0, d[7]}, 32'h0);
            // flag is gone but overrides hold until the next rising input edge
            pins(2'b01);
            pulse(1'b1);
            pulse(1'b0);
            repeat (6) @(negedge aclk);
            rd(cwg_pkg::CWG_STATUS_ADDR);
            chk({31'h0, d[4]}, 32'h0);
        end
        wr(cwg_pkg::CWG_CTRL_ADDR, 32'ha0, 4'h1);
        repeat (3) @(negedge aclk);
        chk({30'h0, pa_oe, pb_oe}, 32'h2);
        wr(cwg_pkg::CWG_CTRL_ADDR, 32'h60, 4'h1);
        repeat (3) @(negedge aclk);
        chk({30'h0, pa_oe, pb_oe}, 32'h0);
        tally_and_finish;
    end
endmodule
